// file: verilog/acfg_pkg.sv
// package: register map, field positions, timing and carrier types of the config bank
package acfg_pkg;

   localparam int unsigned ADDR_W      = 15;
   localparam int unsigned INSTR_BITS  = 16;
   localparam int unsigned BYTE_BITS   = 8;
   localparam int unsigned NUM_IMG     = 9;

   // register offsets
   localparam logic [ADDR_W-1:0] ADDR_CFG_A   = 15'h0000;
   localparam logic [ADDR_W-1:0] ADDR_CFG_B   = 15'h0001;
   localparam logic [ADDR_W-1:0] ADDR_PWR     = 15'h0002;
   localparam logic [ADDR_W-1:0] ADDR_TYPE    = 15'h0003;
   localparam logic [ADDR_W-1:0] ADDR_ID_LO   = 15'h0004;
   localparam logic [ADDR_W-1:0] ADDR_ID_HI   = 15'h0005;
   localparam logic [ADDR_W-1:0] ADDR_GRADE   = 15'h0006;
   localparam logic [ADDR_W-1:0] ADDR_DEV_IDX = 15'h0008;

   // field positions
   localparam int unsigned CFGA_RST_HI = 7;
   localparam int unsigned CFGA_LSB_HI = 6;
   localparam int unsigned CFGA_ASC_HI = 5;
   localparam int unsigned CFGA_ASC_LO = 2;
   localparam int unsigned CFGA_LSB_LO = 1;
   localparam int unsigned CFGA_RST_LO = 0;
   localparam int unsigned CFGB_DP_RST = 1;
   localparam int unsigned GRADE_LSB   = 4;

   // reset values and codes
   localparam logic       LSB_FIRST_RST = 1'b0;
   localparam logic       ASCEND_RST    = 1'b0;
   localparam logic [1:0] DEV_IDX_RST   = 2'h3;
   localparam logic [1:0] PWR_NORMAL    = 2'h0;
   localparam logic [1:0] PWR_STANDBY   = 2'h2;
   localparam logic [1:0] PWR_DOWN      = 2'h3;

   // boot loader wait after power-up or soft reset
   localparam int unsigned BOOT_TIME_MS = 5;
   localparam int unsigned CORE_CLK_HZ  = 40_000_000;
   localparam int unsigned BOOT_CYCLES  = BOOT_TIME_MS * (CORE_CLK_HZ / 1000);

   typedef struct packed {
      logic                         lsb_first;
      logic                         ascend;
      logic [NUM_IMG-1:0][7:0]      bytes;
   } acfg_img_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0]        data;
   } acfg_wr_t;

   function automatic logic [7:0] rev8(input logic [7:0] v);
      return {<<{v}};
   endfunction : rev8

   function automatic logic [15:0] rev16(input logic [15:0] v);
      return {<<{v}};
   endfunction : rev16

endpackage : acfg_pkg

// file: verilog/acfg_link.sv
// serial port engine on the link clock: framing, shifting, address stepping, readback
`timescale 1ns/1ps
module acfg_link (
   input  wire logic                 sclk,
   input  wire logic                 chip_select_n,
   input  wire logic                 rst,
   input  wire logic                 sdi,
   input  wire acfg_pkg::acfg_img_t  img,
   output logic                      sdo,
   output logic                      sdo_oe,
   output acfg_pkg::acfg_wr_t        wr,
   output logic                      wr_tgl
);

   typedef enum logic {PH_INSTR, PH_DATA} acfg_phase_t;

   acfg_phase_t                  phase_q;
   logic [3:0]                   cnt_q;
   logic [15:0]                  sh_q;
   logic                         rw_q;
   logic [acfg_pkg::ADDR_W-1:0]  addr_q;

   wire  [15:0]                  sh_next    = {sh_q[14:0], sdi};
   wire  [15:0]                  instr      = img.lsb_first ? acfg_pkg::rev16(sh_next) : sh_next;
   wire  [7:0]                   byte_in    = img.lsb_first ? acfg_pkg::rev8(sh_next[7:0])
                                                            : sh_next[7:0];
   wire                          instr_last = (cnt_q == 4'(acfg_pkg::INSTR_BITS - 1));
   wire                          byte_last  = (cnt_q == 4'(acfg_pkg::BYTE_BITS - 1));
   wire  [acfg_pkg::ADDR_W-1:0]  addr_step  = img.ascend ? addr_q + 15'h0001
                                                         : addr_q - 15'h0001;
   wire                          in_map     = (addr_q < 15'(acfg_pkg::NUM_IMG));
   wire  [7:0]                   rd_byte    = in_map ? img.bytes[addr_q[3:0]] : 8'h00;
   wire  [2:0]                   bit_idx    = img.lsb_first ? cnt_q[2:0] : 3'h7 - cnt_q[2:0];
   wire                          commit     = (phase_q == PH_DATA) && byte_last && !rw_q;

   ////////////////////////////////////////////////////////////////////////////
   // framing: chip select high holds the frame logic in reset
   always_ff @(posedge sclk or posedge chip_select_n) begin
      if (chip_select_n) begin
         phase_q <= PH_INSTR;
         cnt_q   <= 4'h0;
         sh_q    <= 16'h0000;
         rw_q    <= 1'b0;
         addr_q  <= '0;
      end else begin
         sh_q  <= sh_next;
         cnt_q <= cnt_q + 4'h1;
         case (phase_q)
            PH_INSTR: begin
               if (instr_last) begin
                  phase_q <= PH_DATA;
                  cnt_q   <= 4'h0;
                  rw_q    <= instr[15];
                  addr_q  <= instr[14:0];
               end
            end
            PH_DATA: begin
               if (byte_last) begin
                  cnt_q  <= 4'h0;
                  addr_q <= addr_step;
               end
            end
            default: phase_q <= PH_INSTR;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // write hand-off: word held stable, event carried by a toggle
   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         wr     <= '0;
         wr_tgl <= 1'b0;
      end else if (commit) begin
         wr     <= '{addr: addr_q, data: byte_in};
         wr_tgl <= ~wr_tgl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // readback launched on the falling edge so the host samples on the rising edge
   always_ff @(negedge sclk or posedge chip_select_n) begin
      if (chip_select_n) begin
         sdo    <= 1'b0;
         sdo_oe <= 1'b0;
      end else begin
         sdo_oe <= (phase_q == PH_DATA) && rw_q;
         sdo    <= rd_byte[bit_idx];
      end
   end

endmodule : acfg_link

// file: verilog/acfg_reg_bank.sv
// serial-port configuration register bank of a dual-channel converter
//
// Functional notes
// - each channel keeps its own local register copy
// - both select bits set: write both copies
// - both select bits on read: return first channel
// - global registers ignore channel select bits
// - soft reset bits reset port, registers; self-clear
// - bit order bit: 1 lsb first, 0 msb
// - address step bit: 0 decrement, 1 increment
// - datapath soft reset bit, self clearing pulse
// - power codes normal, standby, power-down per channel
// - power-up or soft reset reloads default register values
// - read-only identifier low, high and type bytes
// - registers eight bits, msb on left
// - read/write bit is the first instruction bit msb first, the last bit lsb first
// - msb first is the power-up default
// - device index bits select channels, reset 3 (both bits 1)
`timescale 1ns/1ps
module acfg_reg_bank #(
   parameter int unsigned BOOT_CYCLES = acfg_pkg::BOOT_CYCLES,
   // identity values below are arbitrary
   parameter logic [7:0]  CHIP_TYPE   = 8'h7c,
   parameter logic [7:0]  PART_ID_LO  = 8'h41,
   parameter logic [7:0]  PART_ID_HI  = 8'h92,
   parameter logic [3:0]  SPEED_CODE  = 4'h0
) (
   input  wire logic       CORE_CLK,
   input  wire logic       RST,
   input  wire logic       SCLK,
   input  wire logic       CHIP_SELECT_N,
   input  wire logic       SDIO_I,
   output logic            SDIO_O,
   output logic            SDIO_OE,
   output logic [1:0]      DP_CLK_EN,
   output logic [1:0]      DP_HOLD_RST,
   output logic [1:0]      SERLINK_EN,
   output logic            DP_SOFT_RST,
   output logic            BOOT_BUSY
);

   localparam int unsigned BOOT_W = $clog2(BOOT_CYCLES + 1);

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   acfg_pkg::acfg_wr_t    wr_word;
   logic                  wr_tgl;
   acfg_pkg::acfg_img_t   img_q;
   acfg_pkg::acfg_img_t   img_d;

   logic                  cs_s1_q;
   logic                  cs_s2_q;
   logic                  tgl_s1_q;
   logic                  tgl_s2_q;
   logic                  tgl_s3_q;

   logic                  lsb_first_q;
   logic                  ascend_q;
   logic [1:0]            dev_idx_q;
   logic [1:0][1:0]       pwr_q;
   logic                  dp_soft_rst_q;
   logic [BOOT_W-1:0]     boot_cnt_q;
   logic                  boot_busy_q;
   logic [1:0]            clk_en_q;
   logic [1:0]            hold_rst_q;
   logic [1:0]            link_en_q;

   ////////////////////////////////////////////////////////////////////////////
   // link engine on the serial clock

   acfg_link u_link (
      .sclk          (SCLK),
      .chip_select_n (CHIP_SELECT_N),
      .rst           (RST),
      .sdi           (SDIO_I),
      .img           (img_q),
      .sdo           (SDIO_O),
      .sdo_oe        (SDIO_OE),
      .wr            (wr_word),
      .wr_tgl        (wr_tgl)
   );

   ////////////////////////////////////////////////////////////////////////////
   // crossings: frame level and write toggle, two flops before any use

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         cs_s1_q  <= 1'b1;
         cs_s2_q  <= 1'b1;
         tgl_s1_q <= 1'b0;
         tgl_s2_q <= 1'b0;
         tgl_s3_q <= 1'b0;
      end else begin
         cs_s1_q  <= CHIP_SELECT_N;
         cs_s2_q  <= cs_s1_q;
         tgl_s1_q <= wr_tgl;
         tgl_s2_q <= tgl_s1_q;
         tgl_s3_q <= tgl_s2_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // write decode

   wire        wr_fire    = tgl_s2_q ^ tgl_s3_q;
   wire [7:0]  wd         = wr_word.data;
   wire        wr_cfg_a   = wr_fire && (wr_word.addr == acfg_pkg::ADDR_CFG_A);
   wire        wr_cfg_b   = wr_fire && (wr_word.addr == acfg_pkg::ADDR_CFG_B);
   wire        wr_pwr     = wr_fire && (wr_word.addr == acfg_pkg::ADDR_PWR);
   wire        wr_idx     = wr_fire && (wr_word.addr == acfg_pkg::ADDR_DEV_IDX);
   wire        soft_rst   = wr_cfg_a && (wd[acfg_pkg::CFGA_RST_HI] ||
                                         wd[acfg_pkg::CFGA_RST_LO]);
   wire        reg_rst    = RST || soft_rst;
   wire        lsb_wr     = wd[acfg_pkg::CFGA_LSB_HI] || wd[acfg_pkg::CFGA_LSB_LO];
   wire        asc_wr     = wd[acfg_pkg::CFGA_ASC_HI] || wd[acfg_pkg::CFGA_ASC_LO];
   wire        only_b     = (dev_idx_q == 2'h2);
   wire [1:0]  rd_pwr     = only_b ? pwr_q[1] : pwr_q[0];

   ////////////////////////////////////////////////////////////////////////////
   // global port configuration, unaffected by channel select

   always_ff @(posedge CORE_CLK) begin
      if (reg_rst) begin
         lsb_first_q <= acfg_pkg::LSB_FIRST_RST;
         ascend_q    <= acfg_pkg::ASCEND_RST;
      end else if (wr_cfg_a) begin
         lsb_first_q <= lsb_wr;
         ascend_q    <= asc_wr;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (reg_rst) begin
         dev_idx_q <= acfg_pkg::DEV_IDX_RST;
      end else if (wr_idx) begin
         dev_idx_q <= wd[1:0];
      end
   end

   // datapath reset is a pulse; the bit itself never holds a 1
   always_ff @(posedge CORE_CLK) begin
      if (reg_rst) begin
         dp_soft_rst_q <= 1'b0;
      end else begin
         dp_soft_rst_q <= wr_cfg_b && wd[acfg_pkg::CFGB_DP_RST];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // local power mode, one copy per channel

   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      always_ff @(posedge CORE_CLK) begin
         if (reg_rst) begin
            pwr_q[ch] <= acfg_pkg::PWR_NORMAL;
         end else if (wr_pwr && dev_idx_q[ch]) begin
            pwr_q[ch] <= wd[1:0];
         end
      end

      always_ff @(posedge CORE_CLK) begin
         if (RST) begin
            clk_en_q[ch]   <= 1'b1;
            hold_rst_q[ch] <= 1'b0;
            link_en_q[ch]  <= 1'b1;
         end else begin
            clk_en_q[ch]   <= (pwr_q[ch] != acfg_pkg::PWR_STANDBY) &&
                              (pwr_q[ch] != acfg_pkg::PWR_DOWN);
            hold_rst_q[ch] <= (pwr_q[ch] == acfg_pkg::PWR_DOWN);
            link_en_q[ch]  <= (pwr_q[ch] != acfg_pkg::PWR_DOWN);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // boot loader time after power-up or soft reset

   always_ff @(posedge CORE_CLK) begin
      if (reg_rst) begin
         boot_cnt_q  <= BOOT_W'(BOOT_CYCLES - 1);
         boot_busy_q <= 1'b1;
      end else if (boot_cnt_q != '0) begin
         boot_cnt_q  <= boot_cnt_q - BOOT_W'(1);
      end else begin
         boot_busy_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // readback image; frozen while a frame is open so the link sees stable words

   always_comb begin
      img_d           = '0;
      img_d.lsb_first = lsb_first_q;
      img_d.ascend    = ascend_q;
      img_d.bytes[acfg_pkg::ADDR_CFG_A][acfg_pkg::CFGA_LSB_HI] = lsb_first_q;
      img_d.bytes[acfg_pkg::ADDR_CFG_A][acfg_pkg::CFGA_LSB_LO] = lsb_first_q;
      img_d.bytes[acfg_pkg::ADDR_CFG_A][acfg_pkg::CFGA_ASC_HI] = ascend_q;
      img_d.bytes[acfg_pkg::ADDR_CFG_A][acfg_pkg::CFGA_ASC_LO] = ascend_q;
      img_d.bytes[acfg_pkg::ADDR_PWR]     = {6'h00, rd_pwr};
      img_d.bytes[acfg_pkg::ADDR_TYPE]    = CHIP_TYPE;
      img_d.bytes[acfg_pkg::ADDR_ID_LO]   = PART_ID_LO;
      img_d.bytes[acfg_pkg::ADDR_ID_HI]   = PART_ID_HI;
      img_d.bytes[acfg_pkg::ADDR_GRADE][7:acfg_pkg::GRADE_LSB] = SPEED_CODE;
      img_d.bytes[acfg_pkg::ADDR_DEV_IDX] = {6'h00, dev_idx_q};
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         img_q <= '0;
      end else if (cs_s2_q) begin
         img_q <= img_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign DP_CLK_EN   = clk_en_q;
   assign DP_HOLD_RST = hold_rst_q;
   assign SERLINK_EN  = link_en_q;
   assign DP_SOFT_RST = dp_soft_rst_q;
   assign BOOT_BUSY   = boot_busy_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   AST_IDX_DEFAULT: assert property (@(posedge CORE_CLK)
      RST |=> (dev_idx_q == acfg_pkg::DEV_IDX_RST) && !lsb_first_q && !ascend_q)
      else $error("device index or port config not at default after reset");

   AST_BOTH_WRITE: assert property (@(posedge CORE_CLK) disable iff (RST)
      (wr_pwr && dev_idx_q == 2'h3) |=> (pwr_q[0] == $past(wd[1:0])) &&
                                       (pwr_q[1] == $past(wd[1:0])))
      else $error("broadcast write missed a channel copy");

   AST_LOCAL_ISOLATE: assert property (@(posedge CORE_CLK) disable iff (RST)
      (wr_pwr && dev_idx_q == 2'h1) |=> (pwr_q[1] == $past(pwr_q[1])) &&
                                       (pwr_q[0] == $past(wd[1:0])))
      else $error("channel A write leaked into channel B copy");

   AST_READ_FIRST: assert property (@(posedge CORE_CLK) disable iff (RST)
      dev_idx_q[0] |-> (img_d.bytes[acfg_pkg::ADDR_PWR][1:0] == pwr_q[0]))
      else $error("readback did not return channel A copy");

   AST_SOFT_RESET: assert property (@(posedge CORE_CLK) disable iff (RST)
      soft_rst |=> (dev_idx_q == acfg_pkg::DEV_IDX_RST) && !lsb_first_q &&
                   (pwr_q == '0) && boot_busy_q ##1 (img_d.bytes[0] == 8'h00))
      else $error("soft reset did not restore defaults or left bits set");

   AST_DP_PULSE: assert property (@(posedge CORE_CLK) disable iff (RST)
      (wr_cfg_b && wd[acfg_pkg::CFGB_DP_RST] && !soft_rst) |=>
         DP_SOFT_RST ##1 !DP_SOFT_RST)
      else $error("datapath reset not a single-cycle pulse");

   AST_PWR_CODES: assert property (@(posedge CORE_CLK) disable iff (RST)
      (pwr_q[0] == acfg_pkg::PWR_STANDBY) ##1 (pwr_q[0] == acfg_pkg::PWR_STANDBY) |->
         !DP_CLK_EN[0] && !DP_HOLD_RST[0] && SERLINK_EN[0])
      else $error("standby outputs wrong");

   AST_PWR_DOWN: assert property (@(posedge CORE_CLK) disable iff (RST)
      (pwr_q[1] == acfg_pkg::PWR_DOWN) |=> !DP_CLK_EN[1] && DP_HOLD_RST[1] && !SERLINK_EN[1])
      else $error("power-down outputs wrong");

   AST_ORDER_WRITE: assert property (@(posedge CORE_CLK) disable iff (RST)
      (wr_cfg_a && !soft_rst) |=> (lsb_first_q == $past(lsb_wr)) &&
                                  (ascend_q == $past(asc_wr)))
      else $error("bit order or step direction not taken from write");

   AST_GRADE_RO: assert property (@(posedge CORE_CLK) disable iff (RST)
      wr_fire && (wr_word.addr == acfg_pkg::ADDR_GRADE) |=>
         (img_d.bytes[acfg_pkg::ADDR_GRADE] == {SPEED_CODE, 4'h0}))
      else $error("grade register changed by a write");

   AST_BOOT_WAIT: assert property (@(posedge CORE_CLK) disable iff (RST)
      $fell(boot_busy_q) |-> $past(boot_cnt_q) == '0)
      else $error("boot wait ended early");

   AST_PWR_STBY_B: assert property (@(posedge CORE_CLK) disable iff (RST)
      (pwr_q[1] == acfg_pkg::PWR_STANDBY) ##1 (pwr_q[1] == acfg_pkg::PWR_STANDBY) |->
         !DP_CLK_EN[1] && !DP_HOLD_RST[1] && SERLINK_EN[1])
      else $error("standby outputs wrong on channel B");

   AST_PWR_DOWN_A: assert property (@(posedge CORE_CLK) disable iff (RST)
      (pwr_q[0] == acfg_pkg::PWR_DOWN) |=>
         !DP_CLK_EN[0] && DP_HOLD_RST[0] && !SERLINK_EN[0])
      else $error("power-down outputs wrong on channel A");

   AST_PWR_NORM_A: assert property (@(posedge CORE_CLK) disable iff (RST)
      (pwr_q[0] == acfg_pkg::PWR_NORMAL) |=>
         DP_CLK_EN[0] && !DP_HOLD_RST[0] && SERLINK_EN[0])
      else $error("normal outputs wrong on channel A");

   AST_PWR_NORM_B: assert property (@(posedge CORE_CLK) disable iff (RST)
      (pwr_q[1] == acfg_pkg::PWR_NORMAL) |=>
         DP_CLK_EN[1] && !DP_HOLD_RST[1] && SERLINK_EN[1])
      else $error("normal outputs wrong on channel B");

   AST_NO_SELECT: assert property (@(posedge CORE_CLK) disable iff (RST)
      (wr_pwr && dev_idx_q == 2'h0) |=>
         (pwr_q == $past(pwr_q)))
      else $error("power write with no channel selected changed a copy");

   AST_READ_B: assert property (@(posedge CORE_CLK) disable iff (RST)
      (dev_idx_q == 2'h2) |->
         (img_d.bytes[acfg_pkg::ADDR_PWR][1:0] == pwr_q[1]))
      else $error("readback did not return channel B copy");

   AST_IDX_WRITE: assert property (@(posedge CORE_CLK) disable iff (RST)
      wr_idx |=>
         (dev_idx_q == $past(wd[1:0])))
      else $error("device index not taken from write");

   AST_GLOBAL_KEEP: assert property (@(posedge CORE_CLK) disable iff (RST)
      (wr_cfg_a && !soft_rst) |=>
         (dev_idx_q == $past(dev_idx_q)) && (pwr_q == $past(pwr_q)))
      else $error("global write disturbed channel state");

   AST_DP_QUIET: assert property (@(posedge CORE_CLK) disable iff (RST)
      !(wr_cfg_b && wd[acfg_pkg::CFGB_DP_RST]) |=>
         !DP_SOFT_RST)
      else $error("datapath reset pulse without a write");

   AST_BOOT_LOAD: assert property (@(posedge CORE_CLK) disable iff (RST)
      soft_rst |=>
         boot_busy_q && (boot_cnt_q == BOOT_W'(BOOT_CYCLES - 1)))
      else $error("soft reset did not restart the boot wait");

   AST_IMG_HOLD: assert property (@(posedge CORE_CLK) disable iff (RST)
      !cs_s2_q |=>
         (img_q == $past(img_q)))
      else $error("readback image changed inside a frame");

endmodule : acfg_reg_bank

// file: verif/acfg_spi_host.sv
// spi host model: frames on the serial port and resolves the shared data wire
`timescale 1ns/1ps
module acfg_spi_host (
   input  wire logic core_clk,
   input  wire logic sdio_dev,
   input  wire logic sdio_dev_oe,
   output logic      sclk,
   output logic      chip_select_n,
   output wire logic sdio_wire
);
   logic host_oe  = 1'b0;
   logic host_d   = 1'b0;
   logic last_q   = 1'b0;
   logic lsb_mode = 1'b0;

   initial begin
      sclk          = 1'b0;
      chip_select_n = 1'b0;
      // a real rising select clears the frame logic out of its unknown state
      #1;
      chip_select_n = 1'b1;
   end

   // a released wire shows the inverse of its last driven level
   assign sdio_wire = sdio_dev_oe ? sdio_dev : (host_oe ? host_d : ~last_q);
   always @(sclk) begin
      if (sdio_dev_oe || host_oe)
         last_q <= sdio_wire;
   end

   ////////////////////////////////////////////////////////////
   // one frame: instruction word, then nb data bytes; clock stands low outside frames
   task automatic frame(input  logic        rd,
                        input  logic [14:0] addr,
                        input  int          nb,
                        input  logic [31:0] wb,
                        output logic [31:0] rb,
                        output logic        oe_bad);
      logic [15:0] w;
      int          idx;
      w      = {rd, addr};
      rb     = 32'h0;
      oe_bad = 1'b0;
      @(negedge core_clk);
      chip_select_n = 1'b0;
      for (int i = 0; i < 16 + 8 * nb; i++) begin
         idx     = 8 * ((i - 16) / 8) + (lsb_mode ? (i % 8) : 7 - (i % 8));
         host_oe = (i < 16) || !rd;
         if (i < 16)
            host_d = lsb_mode ? w[i] : w[15 - i];
         else if (!rd)
            host_d = wb[idx];
         #7.5;
         if (i >= 16 && rd) begin
            rb[idx] = sdio_wire;
            oe_bad  = oe_bad | ~sdio_dev_oe;
         end else
            oe_bad = oe_bad | sdio_dev_oe;
         sclk = 1'b1;
         #7.5;
         sclk = 1'b0;
      end
      host_oe = 1'b0;
      @(negedge core_clk);
      chip_select_n = 1'b1;
      repeat (6) @(negedge core_clk);
   endtask : frame
endmodule : acfg_spi_host

// file: verif/test_adc_spi_config_register_bank.sv
// self-checking bench of the serial-port config register bank
`timescale 1ns/1ps
module test_adc_spi_config_register_bank;
   localparam int unsigned BOOT    = 20;
   // identity values are arbitrary
   localparam logic [7:0]  TYPE_V  = 8'h5a;
   localparam logic [7:0]  ID_LO_V = 8'h3c;
   localparam logic [7:0]  ID_HI_V = 8'hc3;
   localparam logic [3:0]  SPEED_V = 4'h1;

   logic       core_clk    = 1'b0;
   logic       rst         = 1'b0;
   wire logic  sclk;
   wire logic  csn;
   wire logic  sdio_in;
   logic       sdio_out;
   logic       sdio_oe;
   logic       dp_soft_rst;
   logic       boot_busy;
   logic [1:0] dp_clk_en;
   logic [1:0] dp_hold_rst;
   logic [1:0] serlink_en;
   int         error_cnt   = 0;
   int         checks_done = 0;
   int         pulse_cnt   = 0;

   always #12.5 core_clk = ~core_clk;
   always @(negedge core_clk) begin
      if (dp_soft_rst === 1'b1)
         pulse_cnt++;
   end

   acfg_reg_bank #(
      .BOOT_CYCLES (BOOT),
      .CHIP_TYPE   (TYPE_V),
      .PART_ID_LO  (ID_LO_V),
      .PART_ID_HI  (ID_HI_V),
      .SPEED_CODE  (SPEED_V)
   ) u_acfg_reg_bank (
      .CORE_CLK      (core_clk),
      .RST           (rst),
      .SCLK          (sclk),
      .CHIP_SELECT_N (csn),
      .SDIO_I        (sdio_in),
      .SDIO_O        (sdio_out),
      .SDIO_OE       (sdio_oe),
      .DP_CLK_EN     (dp_clk_en),
      .DP_HOLD_RST   (dp_hold_rst),
      .SERLINK_EN    (serlink_en),
      .DP_SOFT_RST   (dp_soft_rst),
      .BOOT_BUSY     (boot_busy)
   );

   acfg_spi_host u_acfg_spi_host (
      .core_clk      (core_clk),
      .sdio_dev      (sdio_out),
      .sdio_dev_oe   (sdio_oe),
      .sclk          (sclk),
      .chip_select_n (csn),
      .sdio_wire     (sdio_in)
   );

   ////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test;
      if (error_cnt == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test

   task automatic xfer(input logic rd, input logic [14:0] a, input int nb,
                       input logic [31:0] wb, output logic [31:0] rb);
      logic bad;
      u_acfg_spi_host.frame(rd, a, nb, wb, rb, bad);
      check({7'h0, bad}, 8'h00);
      check({7'h0, sdio_oe}, 8'h00);
   endtask : xfer

   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic [31:0] rb;
      xfer(1'b0, a, 1, {24'h0, d}, rb);
   endtask : wr

   task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp);
      logic [31:0] rb;
      xfer(1'b1, a, 1, 32'h0, rb);
      check(rb[7:0], exp);
   endtask : rd_chk

   task automatic outs(input logic [1:0] ce, input logic [1:0] hr, input logic [1:0] le);
      check({6'h0, dp_clk_en}, {6'h0, ce});
      check({6'h0, dp_hold_rst}, {6'h0, hr});
      check({6'h0, serlink_en}, {6'h0, le});
   endtask : outs

   // the host keeps off the port until the boot wait is over
   task automatic wait_boot;
      int n;
      n = 0;
      while (boot_busy !== 1'b0 && n < 4 * BOOT) begin
         @(negedge core_clk);
         n++;
      end
      check({7'h0, boot_busy}, 8'h00);
   endtask : wait_boot

   ////////////////////////////////////////////////////////////
   task automatic t_defaults;
      logic [7:0] exp_v [9];
      exp_v = '{8'h00, 8'h00, 8'h00, TYPE_V, ID_LO_V, ID_HI_V, {SPEED_V, 4'h0}, 8'h00, 8'h03};
      for (int a = 0; a < 9; a++)
         rd_chk(15'(a), exp_v[a]);
      outs(2'b11, 2'b00, 2'b11);
      wr(15'h0003, 8'hff);
      wr(15'h0006, 8'hff);
      rd_chk(15'h0003, TYPE_V);
      rd_chk(15'h0006, {SPEED_V, 4'h0});
      rd_chk(15'h0013, 8'h00);
   endtask : t_defaults

   task automatic t_channels;
      wr(15'h0008, 8'h01);
      wr(15'h0002, 8'h03);
      outs(2'b10, 2'b01, 2'b10);
      wr(15'h0008, 8'h02);
      wr(15'h0002, 8'h02);
      outs(2'b00, 2'b01, 2'b10);
      rd_chk(15'h0002, 8'h02);
      wr(15'h0008, 8'h01);
      rd_chk(15'h0002, 8'h03);
      wr(15'h0008, 8'h03);
      rd_chk(15'h0002, 8'h03);
      wr(15'h0002, 8'h02);
      outs(2'b00, 2'b00, 2'b11);
      wr(15'h0002, 8'h00);
      outs(2'b11, 2'b00, 2'b11);
      wr(15'h0008, 8'h00);
      wr(15'h0002, 8'h03);
      outs(2'b11, 2'b00, 2'b11);
      wr(15'h0000, 8'h04);
      rd_chk(15'h0000, 8'h24);
      rd_chk(15'h0008, 8'h00);
   endtask : t_channels

   task automatic t_multibyte;
      logic [31:0] rb;
      xfer(1'b1, 15'h0003, 3, 32'h0, rb);
      check(rb[23:16], ID_HI_V);
      check(rb[15:8], ID_LO_V);
      wr(15'h0000, 8'h00);
      xfer(1'b1, 15'h0005, 3, 32'h0, rb);
      check(rb[23:16], TYPE_V);
      check(rb[15:8], ID_LO_V);
   endtask : t_multibyte

   task automatic t_lsb;
      wr(15'h0000, 8'h02);
      u_acfg_spi_host.lsb_mode = 1'b1;
      rd_chk(15'h0004, ID_LO_V);
      rd_chk(15'h0000, 8'h42);
      wr(15'h0000, 8'h00);
      u_acfg_spi_host.lsb_mode = 1'b0;
      rd_chk(15'h0000, 8'h00);
   endtask : t_lsb

   task automatic t_dp_reset;
      int n;
      n = pulse_cnt;
      wr(15'h0001, 8'h02);
      check(8'(pulse_cnt - n), 8'h01);
      rd_chk(15'h0001, 8'h00);
      outs(2'b11, 2'b00, 2'b11);
   endtask : t_dp_reset

   task automatic t_soft_reset;
      for (int i = 0; i < 2; i++) begin
         wr(15'h0008, 8'h03);
         wr(15'h0002, 8'h03);
         wr(15'h0008, 8'h01);
         wr(15'h0000, 8'h24);
         wr(15'h0000, (i == 0) ? 8'h81 : 8'h01);
         check({7'h0, boot_busy}, 8'h01);
         wait_boot;
         rd_chk(15'h0000, 8'h00);
         rd_chk(15'h0008, 8'h03);
         rd_chk(15'h0002, 8'h00);
         outs(2'b11, 2'b00, 2'b11);
      end
   endtask : t_soft_reset

   ////////////////////////////////////////////////////////////
   initial begin
      // a real rising reset so the link's asynchronous reset fires
      #1;
      rst = 1'b1;
      repeat (10) @(negedge core_clk);
      rst = 1'b0;
      wait_boot;
      t_defaults;
      t_channels;
      t_multibyte;
      t_lsb;
      t_dp_reset;
      t_soft_reset;
      end_of_test;
   end

   initial begin
      #200_000;
      error_cnt++;
      end_of_test;
   end
endmodule : test_adc_spi_config_register_bank
